/* rtl/lcd_bias_power_control.sv */
// Display voltage source, bias level, deep sleep and pin duty control
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
// Functional notes
// - Pump off while display disabled
// - Six-bit contrast code, 64 levels
// - Source select resets to pump
// - Ladder source ignores contrast code
// - Deep sleep display on only if allowed
// - Display off keeps configuration and data
// - Sixteen low segment pins always routed
// - Four-way mux turns shared pins commons
// - Shared pins segment only when enabled
// - Clear bit and reset zero memory
module lcd_bias_power_control #(
   parameter int unsigned ADR_W = 10
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 reset_n_i,
   // Wishbone slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [ADR_W-1:0]     wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   // Power state
   input  wire logic                 deep_sleep_mode_i,
   input  wire logic                 sleep_reference_enable_i,
   // Voltage generation
   output logic                      pump_enable_o,
   output logic                      ladder_source_select_o,
   output logic      [5:0]           contrast_level_code_o,
   output logic                      bias_mode_o,
   output logic                      display_active_o,
   // Pin duty
   output logic      [3:0]           common_enable_o,
   output logic      [28:0]          segment_pin_enable_o,
   // Segment image
   output logic      [119:0]         segment_data_o
);
   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0]  display_configuration;
   logic [7:0]  display_voltage_configuration;
   logic [7:0]  segment_pin_enable_first;
   logic [7:0]  segment_pin_enable_second;
   logic [7:0]  mem_pointer;
   logic [7:0]  mem_data;
   logic        clear_req;
   logic [7:0]  mem_rd_data;

   logic [7:0]  index;
   logic        access;
   logic        wr_req;
   logic        ptr_wr;
   logic        mem_wr;
   logic [7:0]  read_value;

   logic        display_enable;
   logic        sleep_display_off;
   logic        ladder_source_select;
   logic [1:0]  mux_code;
   logic [5:0]  contrast_level_code;
   logic        next_active;
   logic [3:0]  next_commons;
   logic [28:0] next_pins;

   assign index    = wb_adr_i[9:2];
   assign access   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_req   = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   assign ptr_wr   = wr_req && index == lcd_bias_pkg::IDX_MEM_PTR;
   assign mem_wr   = ptr_wr && wb_dat_i[lcd_bias_pkg::PTR_WRITE_BIT];

   assign display_enable       = display_configuration[lcd_bias_pkg::CFG_ENABLE_BIT];
   assign sleep_display_off    = display_configuration[lcd_bias_pkg::CFG_SLEEP_OFF_BIT];
   assign mux_code             = display_configuration[lcd_bias_pkg::CFG_MUX_LSB +: 2];
   assign ladder_source_select = display_voltage_configuration[lcd_bias_pkg::VOLT_LADDER_BIT];
   assign contrast_level_code  = display_voltage_configuration[lcd_bias_pkg::VOLT_CODE_LSB +: lcd_bias_pkg::CODE_W];

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= access;
      end
   end

   always_comb begin
      read_value = 8'h00;
      case (index)
         lcd_bias_pkg::IDX_DISP_CFG: begin
            read_value = display_configuration;
         end
         lcd_bias_pkg::IDX_SEG_EN1: begin
            read_value = segment_pin_enable_first;
         end
         lcd_bias_pkg::IDX_VOLT_CFG: begin
            read_value = display_voltage_configuration;
         end
         lcd_bias_pkg::IDX_SEG_EN2: begin
            read_value = segment_pin_enable_second;
         end
         lcd_bias_pkg::IDX_MEM_PTR: begin
            read_value = mem_pointer;
         end
         lcd_bias_pkg::IDX_MEM_DATA: begin
            read_value = mem_data;
         end
         lcd_bias_pkg::IDX_STATUS: begin
            read_value = {4'h0, deep_sleep_mode_i, ladder_source_select_o, pump_enable_o, display_active_o};
         end
         default: begin
            read_value = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (access && !wb_we_i) begin
         wb_dat_o <= {24'h00_0000, read_value};
      end else begin
         wb_dat_o <= 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   // only writes or reset alter these
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         display_configuration <= lcd_bias_pkg::DISP_CFG_RESET;
      end else if (wr_req && index == lcd_bias_pkg::IDX_DISP_CFG) begin
         display_configuration <= wb_dat_i[7:0] & ~(8'h01 << lcd_bias_pkg::CFG_CLEAR_BIT);
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         display_voltage_configuration <= lcd_bias_pkg::VOLT_CFG_RESET;
      end else if (wr_req && index == lcd_bias_pkg::IDX_VOLT_CFG) begin
         display_voltage_configuration <= wb_dat_i[7:0] & 8'hbf;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         segment_pin_enable_first <= lcd_bias_pkg::SEG_EN_RESET;
      end else if (wr_req && index == lcd_bias_pkg::IDX_SEG_EN1) begin
         segment_pin_enable_first <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         segment_pin_enable_second <= lcd_bias_pkg::SEG_EN_RESET;
      end else if (wr_req && index == lcd_bias_pkg::IDX_SEG_EN2) begin
         segment_pin_enable_second <= {6'h00, wb_dat_i[1:0]};
      end
   end

   // ----------------------------------------------------------------
   // Segment memory access
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mem_pointer <= lcd_bias_pkg::MEM_RESET;
      end else if (ptr_wr) begin
         mem_pointer <= wb_dat_i[7:0];
      end
   end

   // Pointer write with top bit clear fetches a byte
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mem_data <= lcd_bias_pkg::MEM_RESET;
      end else if (ptr_wr && !wb_dat_i[lcd_bias_pkg::PTR_WRITE_BIT]) begin
         mem_data <= mem_rd_data;
      end else if (wr_req && index == lcd_bias_pkg::IDX_MEM_DATA) begin
         mem_data <= wb_dat_i[7:0];
      end
   end

   // clear request from the configuration write
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         clear_req <= 1'b0;
      end else begin
         clear_req <= wr_req && index == lcd_bias_pkg::IDX_DISP_CFG && wb_dat_i[lcd_bias_pkg::CFG_CLEAR_BIT];
      end
   end

   seg_data_memory #(
      .DEPTH (lcd_bias_pkg::MEM_DEPTH),
      .WIDTH (8)
   ) u_mem (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .clear_i   (clear_req),
      .wr_en_i   (mem_wr),
      .addr_i    (wb_dat_i[3:0]),
      .wr_data_i (mem_data),
      .rd_data_o (mem_rd_data),
      .image_o   (segment_data_o)
   );

   // ----------------------------------------------------------------
   // Display power state
   // ----------------------------------------------------------------
   always_comb begin
      next_active = display_enable;
      if (deep_sleep_mode_i) begin
         // needs the reference in deep sleep
         next_active = display_enable && !sleep_display_off && sleep_reference_enable_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         display_active_o <= 1'b0;
      end else begin
         display_active_o <= next_active;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pump_enable_o <= 1'b0;
      end else begin
         pump_enable_o <= next_active && !ladder_source_select;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         contrast_level_code_o <= 6'h00;
      end else if (ladder_source_select) begin
         contrast_level_code_o <= 6'h00;
      end else begin
         contrast_level_code_o <= contrast_level_code;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ladder_source_select_o <= 1'b0;
         bias_mode_o            <= 1'b0;
      end else begin
         ladder_source_select_o <= ladder_source_select;
         bias_mode_o            <= display_configuration[lcd_bias_pkg::CFG_BIAS_BIT];
      end
   end

   // ----------------------------------------------------------------
   // Pin duty
   // ----------------------------------------------------------------
   always_comb begin
      case (mux_code)
         lcd_bias_pkg::MUX_2X: begin
            next_commons = 4'h3;
         end
         lcd_bias_pkg::MUX_3X: begin
            next_commons = 4'h7;
         end
         lcd_bias_pkg::MUX_4X: begin
            next_commons = 4'hf;
         end
         default: begin
            next_commons = 4'h1;
         end
      endcase
   end

   always_comb begin
      next_pins = lcd_bias_pkg::PIN_RESET;
      next_pins[23:16] = segment_pin_enable_first;
      next_pins[25:24] = segment_pin_enable_second[1:0];
      next_pins[27] = mux_code != lcd_bias_pkg::MUX_4X;
      next_pins[28] = mux_code != lcd_bias_pkg::MUX_4X && mux_code != lcd_bias_pkg::MUX_3X;
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         common_enable_o      <= lcd_bias_pkg::COM_RESET;
         segment_pin_enable_o <= lcd_bias_pkg::PIN_RESET;
      end else begin
         common_enable_o      <= next_commons;
         segment_pin_enable_o <= next_pins;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   sequence s_clear_write;
      wr_req && index == lcd_bias_pkg::IDX_DISP_CFG && wb_dat_i[lcd_bias_pkg::CFG_CLEAR_BIT];
   endsequence

   sequence s_memory_zero;
      segment_data_o == 120'h0;
   endsequence

   a_pump_off_disabled: assert property (!display_enable |=> !pump_enable_o)
      else $error("pump running while display disabled");

   a_code_passthrough: assert property (!ladder_source_select |=>
      contrast_level_code_o == $past(contrast_level_code))
      else $error("contrast code not forwarded");

   a_source_reset_pump: assert property (@(posedge clk_i) disable iff (1'b0)
      !reset_n_i |=> !ladder_source_select && !ladder_source_select_o)
      else $error("source select not pump after reset");

   a_ladder_masks_code: assert property (ladder_source_select |=>
      !pump_enable_o && contrast_level_code_o == 6'h00)
      else $error("ladder source still drives pump or code");

   a_sleep_off_forces: assert property (deep_sleep_mode_i && (sleep_display_off || !display_enable)
      |=> !display_active_o)
      else $error("display on in deep sleep against control bits");

   a_sleep_display_on: assert property (deep_sleep_mode_i && display_enable && !sleep_display_off &&
      sleep_reference_enable_i |=> display_active_o)
      else $error("display off in deep sleep though allowed");

   a_config_retained: assert property (!display_enable && !wr_req |=>
      $stable(display_voltage_configuration) && $stable(segment_pin_enable_first) &&
      $stable(segment_pin_enable_second))
      else $error("configuration lost while display off");

   a_fixed_segments: assert property (segment_pin_enable_o[15:0] == 16'hffff)
      else $error("low segment pins not routed");

   a_mux4_commons: assert property (mux_code == lcd_bias_pkg::MUX_4X |=>
      common_enable_o == 4'hf && !segment_pin_enable_o[27] && !segment_pin_enable_o[28])
      else $error("four-way mux pins not commons");

   a_shared_enables: assert property (##1 segment_pin_enable_o[23:16] == $past(segment_pin_enable_first) &&
      segment_pin_enable_o[25:24] == $past(segment_pin_enable_second[1:0]))
      else $error("shared pin duty differs from enables");

   a_clear_memory: assert property (s_clear_write |-> ##2 s_memory_zero)
      else $error("segment memory not cleared");

   a_pump_restart: assert property ($rose(display_enable) && !ladder_source_select && !deep_sleep_mode_i
      |=> pump_enable_o && contrast_level_code_o == $past(contrast_level_code))
      else $error("pump not restarted with stored code");

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held more than one cycle");
endmodule : lcd_bias_power_control

/* rtl/lcd_bias_pkg.sv */
// Constants for the display bias, power and pin control block
package lcd_bias_pkg;
   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_DISP_CFG  = 8'h95;
   localparam logic [7:0] IDX_SEG_EN1   = 8'h97;
   localparam logic [7:0] IDX_VOLT_CFG  = 8'h9c;
   localparam logic [7:0] IDX_SEG_EN2   = 8'hed;
   localparam logic [7:0] IDX_MEM_PTR   = 8'ha8;
   localparam logic [7:0] IDX_MEM_DATA  = 8'ha9;
   localparam logic [7:0] IDX_STATUS    = 8'haa;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned CFG_MUX_LSB       = 0;
   localparam int unsigned CFG_BIAS_BIT      = 2;
   localparam int unsigned CFG_CLEAR_BIT     = 4;
   localparam int unsigned CFG_SLEEP_OFF_BIT = 6;
   localparam int unsigned CFG_ENABLE_BIT    = 7;
   localparam int unsigned VOLT_CODE_LSB     = 0;
   localparam int unsigned VOLT_LADDER_BIT   = 7;
   localparam int unsigned PTR_WRITE_BIT     = 7;
   localparam int unsigned CODE_W            = 6;
   localparam int unsigned SEG_EN2_W         = 2;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  DISP_CFG_RESET = 8'h00;
   localparam logic [7:0]  VOLT_CFG_RESET = 8'h00;
   localparam logic [7:0]  SEG_EN_RESET   = 8'h00;
   localparam logic [7:0]  MEM_RESET      = 8'h00;
   localparam logic [28:0] PIN_RESET      = 29'h1c00_ffff;
   localparam logic [3:0]  COM_RESET      = 4'h1;

   // ----------------------------------------------------------------
   // Memory, pins and multiplex codes
   // ----------------------------------------------------------------
   localparam int unsigned MEM_DEPTH   = 15;
   localparam int unsigned PIN_COUNT   = 29;
   localparam logic [1:0]  MUX_2X      = 2'h1;
   localparam logic [1:0]  MUX_3X      = 2'h2;
   localparam logic [1:0]  MUX_4X      = 2'h3;
endpackage : lcd_bias_pkg

/* rtl/seg_data_memory.sv */
// Segment data memory with bulk clear
`timescale 1ns/100ps
module seg_data_memory #(
   parameter int unsigned DEPTH = 15,
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset
   input  wire logic                   clk_i,
   input  wire logic                   reset_n_i,
   // Access port
   input  wire logic                   clear_i,
   input  wire logic                   wr_en_i,
   input  wire logic [3:0]             addr_i,
   input  wire logic [WIDTH-1:0]       wr_data_i,
   output logic      [WIDTH-1:0]       rd_data_o,
   // Display image
   output logic      [DEPTH*WIDTH-1:0] image_o
);
   logic [WIDTH-1:0] mem [DEPTH];

   // ----------------------------------------------------------------
   // Storage, clear beats write
   // ----------------------------------------------------------------
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk_i) begin
         if (!reset_n_i || clear_i) begin
            mem[i] <= '0;
         end else if (wr_en_i && addr_i == 4'(i)) begin
            mem[i] <= wr_data_i;
         end
      end
      assign image_o[i*WIDTH +: WIDTH] = mem[i];
   end

   always_comb begin
      rd_data_o = '0;
      if (32'(addr_i) < DEPTH) begin
         rd_data_o = mem[addr_i];
      end
   end
endmodule : seg_data_memory

/* test/lcd_panel_model.sv */
// Behavioural glass panel as seen from the waveform drive side
`timescale 1ns/100ps
module lcd_panel_model (
   // Drive from the block
   input  wire logic         pump_enable_i,
   input  wire logic         ladder_source_select_i,
   input  wire logic [5:0]   contrast_level_code_i,
   input  wire logic [3:0]   common_enable_i,
   input  wire logic [119:0] segment_data_i,
   // Panel view
   output logic      [1:0]   rail_source_o,
   output logic      [5:0]   rail_code_o,
   output logic              lit_o
);
   // Ladder rails are fixed; pump rails follow the code
   always_comb begin
      rail_source_o = 2'h0;
      rail_code_o   = 6'h00;
      if (ladder_source_select_i) begin
         rail_source_o = 2'h2;
      end else if (pump_enable_i) begin
         rail_source_o = 2'h1;
         rail_code_o   = contrast_level_code_i;
      end
   end
   assign lit_o = (rail_source_o != 2'h0) && common_enable_i[0] && (|segment_data_i);
endmodule : lcd_panel_model

/* test/lcd_bias_power_control_tb.sv */
// Self-checking bench for the display bias, power and pin control block
`timescale 1ns/100ps
module lcd_bias_power_control_tb;
   logic         clk_i                    = 1'b0;
   logic         reset_n_i                = 1'b0;
   logic         wb_cyc_i                 = 1'b0;
   logic         wb_stb_i                 = 1'b0;
   logic         wb_we_i                  = 1'b0;
   logic [9:0]   wb_adr_i                 = 10'h000;
   logic [3:0]   wb_sel_i                 = 4'h0;
   logic [31:0]  wb_dat_i                 = 32'h0000_0000;
   logic         deep_sleep_mode_i        = 1'b0;
   logic         sleep_reference_enable_i = 1'b0;
   logic [31:0]  wb_dat_o;
   logic         wb_ack_o;
   logic         pump_enable_o;
   logic         ladder_source_select_o;
   logic [5:0]   contrast_level_code_o;
   logic         bias_mode_o;
   logic         display_active_o;
   logic [3:0]   common_enable_o;
   logic [28:0]  segment_pin_enable_o;
   logic [119:0] segment_data_o;
   logic [1:0]   rail_source;
   logic [5:0]   rail_code;
   logic         panel_lit;
   int           bad_count = 0;
   int           compares  = 0;
   int unsigned  seed;

   always #4 clk_i = ~clk_i;

   lcd_bias_power_control DUT (
      .clk_i(clk_i), .reset_n_i(reset_n_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .deep_sleep_mode_i(deep_sleep_mode_i), .sleep_reference_enable_i(sleep_reference_enable_i),
      .pump_enable_o(pump_enable_o), .ladder_source_select_o(ladder_source_select_o),
      .contrast_level_code_o(contrast_level_code_o), .bias_mode_o(bias_mode_o),
      .display_active_o(display_active_o), .common_enable_o(common_enable_o),
      .segment_pin_enable_o(segment_pin_enable_o), .segment_data_o(segment_data_o)
   );

   lcd_panel_model panel (
      .pump_enable_i(pump_enable_o), .ladder_source_select_i(ladder_source_select_o),
      .contrast_level_code_i(contrast_level_code_o), .common_enable_i(common_enable_o),
      .segment_data_i(segment_data_o), .rail_source_o(rail_source), .rail_code_o(rail_code),
      .lit_o(panel_lit)
   );

   // ----------------------------------------------------------------
   // Compare, bus and expectation helpers
   // ----------------------------------------------------------------
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check_byte

   task automatic check_port(input string what, input logic [119:0] seen, input logic [119:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check_port

   task automatic bus(input logic [7:0] idx, input logic we, input logic [7:0] wd, output logic [7:0] rd);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= 4'h1;
      wb_dat_i <= {24'h00_0000, wd};
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
   endtask : bus

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] q;
      bus(idx, 1'b1, d, q);
   endtask : wr

   task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] q;
      bus(idx, 1'b0, 8'h00, q);
      check_byte(what, exp, q);
   endtask : rd_chk

   function automatic logic [28:0] exp_pins(input logic [1:0] m, input logic [7:0] s1, input logic [7:0] s2);
      logic [28:0] p;
      p = 29'h0400_ffff;
      p[23:16] = s1;
      p[25:24] = s2[1:0];
      p[27] = (m != 2'h3);
      p[28] = (m < 2'h2);
      return p;
   endfunction : exp_pins

   task automatic print_verdict();
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      print_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0]   code;
      logic [7:0]   s1;
      logic [7:0]   s2;
      logic [7:0]   d;
      logic [119:0] img;
      logic [7:0]   codes [3];
      seed = $urandom(49);
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      check_port("pins", 120'(segment_pin_enable_o), 120'(lcd_bias_pkg::PIN_RESET));
      check_port("commons", 120'(common_enable_o), 120'(lcd_bias_pkg::COM_RESET));
      check_port("ladder", 120'(ladder_source_select_o), 120'h0);
      check_port("image", segment_data_o, 120'h0);
      rd_chk("volt_cfg", lcd_bias_pkg::IDX_VOLT_CFG, lcd_bias_pkg::VOLT_CFG_RESET);
      rd_chk("disp_cfg", lcd_bias_pkg::IDX_DISP_CFG, lcd_bias_pkg::DISP_CFG_RESET);
      // Pump on, off and ladder for corner and random codes
      codes = '{8'h00, 8'h3f, 8'($urandom) & 8'h3f};
      foreach (codes[i]) begin
         code = codes[i];
         wr(lcd_bias_pkg::IDX_VOLT_CFG, code);
         wr(lcd_bias_pkg::IDX_DISP_CFG, 8'h80);
         repeat (2) @(posedge clk_i);
         check_port("pump_on", 120'(pump_enable_o), 120'h1);
         check_port("code", 120'(contrast_level_code_o), 120'(code[5:0]));
         check_port("rail_code", 120'(rail_code), 120'(code[5:0]));
         wr(lcd_bias_pkg::IDX_DISP_CFG, 8'h00);
         repeat (2) @(posedge clk_i);
         check_port("pump_off", 120'(pump_enable_o), 120'h0);
         rd_chk("volt_kept", lcd_bias_pkg::IDX_VOLT_CFG, code);
         wr(lcd_bias_pkg::IDX_VOLT_CFG, 8'h80 | code);
         wr(lcd_bias_pkg::IDX_DISP_CFG, 8'h84);
         repeat (2) @(posedge clk_i);
         check_port("ladder", 120'(ladder_source_select_o), 120'h1);
         check_port("code_lad", 120'(contrast_level_code_o), 120'h0);
         check_port("rail_src", 120'(rail_source), 120'h2);
         check_port("bias", 120'(bias_mode_o), 120'h1);
         rd_chk("volt_lad", lcd_bias_pkg::IDX_VOLT_CFG, 8'h80 | code);
         wr(lcd_bias_pkg::IDX_VOLT_CFG, 8'h00);
      end
      // Deep sleep table over enable, sleep-off, sleep and reference
      for (int i = 0; i < 16; i++) begin
         deep_sleep_mode_i        <= i[2];
         sleep_reference_enable_i <= i[3];
         wr(lcd_bias_pkg::IDX_DISP_CFG, {i[1], i[0], 6'h00});
         repeat (2) @(posedge clk_i);
         check_port("active", 120'(display_active_o),
                    120'(i[1] & (~i[2] | (~i[0] & i[3]))));
         rd_chk("status", lcd_bias_pkg::IDX_STATUS,
                {4'h0, i[2], 1'b0, {2{i[1] & (~i[2] | (~i[0] & i[3]))}}});
      end
      deep_sleep_mode_i        <= 1'b0;
      sleep_reference_enable_i <= 1'b0;
      // Multiplex codes with random shared pin enables
      for (int m = 0; m < 4; m++) begin
         s1 = 8'($urandom);
         s2 = 8'($urandom);
         wr(lcd_bias_pkg::IDX_SEG_EN1, s1);
         wr(lcd_bias_pkg::IDX_SEG_EN2, s2);
         wr(lcd_bias_pkg::IDX_DISP_CFG, 8'(m));
         repeat (2) @(posedge clk_i);
         check_port("commons", 120'(common_enable_o), 120'((4'h2 << m) - 4'h1));
         check_port("pins", 120'(segment_pin_enable_o), 120'(exp_pins(2'(m), s1, s2)));
         rd_chk("seg_en2", lcd_bias_pkg::IDX_SEG_EN2, s2 & 8'h03);
      end
      // Segment memory fill, retention, readback and clear
      img = 120'h0;
      for (int e = 0; e < 15; e++) begin
         d = 8'($urandom);
         img[8*e +: 8] = d;
         wr(lcd_bias_pkg::IDX_MEM_DATA, d);
         wr(lcd_bias_pkg::IDX_MEM_PTR, 8'h80 | 8'(e));
      end
      wr(lcd_bias_pkg::IDX_DISP_CFG, 8'h80);
      wr(lcd_bias_pkg::IDX_DISP_CFG, 8'h00);
      repeat (2) @(posedge clk_i);
      check_port("image", segment_data_o, img);
      wr(lcd_bias_pkg::IDX_MEM_PTR, 8'h0e);
      rd_chk("mem_rd", lcd_bias_pkg::IDX_MEM_DATA, img[119:112]);
      wr(8'h10, 8'hff);
      rd_chk("unmapped", 8'h10, 8'h00);
      wr(lcd_bias_pkg::IDX_DISP_CFG, 8'h10);
      repeat (2) @(posedge clk_i);
      check_port("cleared", segment_data_o, 120'h0);
      rd_chk("clr_bit", lcd_bias_pkg::IDX_DISP_CFG, 8'h00);
      print_verdict();
   end
endmodule : lcd_bias_power_control_tb
